// ===== core/timer_pkg.sv
// Shared constants, register map and types of the dual timer core
package timer_pkg;
  // Register byte offsets on the Wishbone bus
  localparam logic [7:0] OFS_CTRL0   = 8'h00;
  localparam logic [7:0] OFS_CTRL1   = 8'h04;
  localparam logic [7:0] OFS_PERIOD0 = 8'h08;
  localparam logic [7:0] OFS_PERIOD1 = 8'h0C;
  localparam logic [7:0] OFS_WIDTH0  = 8'h10;
  localparam logic [7:0] OFS_WIDTH1  = 8'h14;
  localparam logic [7:0] OFS_COUNT0  = 8'h18;
  localparam logic [7:0] OFS_COUNT1  = 8'h1C;
  localparam logic [7:0] OFS_STATUS  = 8'h20;
  localparam logic [7:0] OFS_MASK    = 8'h24;
  localparam logic [7:0] OFS_CONFIG  = 8'h28;

  // Fields of unit_control_reg
  localparam int CTRL_PRESET_BIT = 7;
  localparam int CTRL_CLK_LSB    = 4;
  localparam int CTRL_RUN_BIT    = 3;
  localparam int CTRL_MODE_LSB   = 0;
  // Fields of the configuration register
  localparam int CFG_TAP_BIT     = 0;
  localparam int CFG_LOWSPD_BIT  = 1;

  // Reset values
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'h00;
  localparam logic [7:0] WIDTH_RESET  = 8'h00;
  localparam logic [1:0] IRQ_RESET    = 2'h0;
  localparam logic [1:0] CFG_RESET    = 2'h0;

  // Prescaler taps, as powers of two of the high-frequency clock
  localparam int DIV_BITS   = 11;
  localparam int TAP_SLOW   = 11;
  localparam int TAP_MID1   = 7;
  localparam int TAP_MID2   = 5;
  localparam int TAP_FAST   = 3;
  localparam int FS_DIV_BITS = 3;

  // Clock select codes
  localparam logic [2:0] CK_TAP11 = 3'h0;
  localparam logic [2:0] CK_TAP7  = 3'h1;
  localparam logic [2:0] CK_TAP5  = 3'h2;
  localparam logic [2:0] CK_TAP3  = 3'h3;
  localparam logic [2:0] CK_FS    = 3'h4;
  localparam logic [2:0] CK_FC2   = 3'h5;
  localparam logic [2:0] CK_FC    = 3'h6;
  localparam logic [2:0] CK_PIN   = 3'h7;
  localparam int NUM_INT_TICKS    = 7;

  // Unit mode codes
  localparam logic [2:0] MODE_TIMER8  = 3'h0;
  localparam logic [2:0] MODE_DIV8    = 3'h1;
  localparam logic [2:0] MODE_PWM8    = 3'h2;
  localparam logic [2:0] MODE_RSVD    = 3'h3;
  localparam logic [2:0] MODE_TIMER16 = 3'h4;
  localparam logic [2:0] MODE_WARMUP  = 3'h5;
  localparam logic [2:0] MODE_PWM16   = 3'h6;
  localparam logic [2:0] MODE_PPG16   = 3'h7;

  // Counting behaviour of one counter
  typedef enum logic [1:0] {
    kind_timer,
    kind_div,
    kind_pwm,
    kind_ppg
  } kind_e;
endpackage

// ===== core/tick_if.sv
// Tick strobes from the clock source generator to the counters
interface tick_if;
  logic [6:0] tick;
  logic [1:0] pin_fall;

  modport source (output tick, output pin_fall);
  modport sink   (input tick, input pin_fall);
endinterface

// ===== core/clock_source_gen.sv
// Prescaler taps, low-frequency clock and event pin edge strobes
module clock_source_gen
  import timer_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic tap_select_i,
  input  wire logic low_freq_clock_i,
  input  wire logic [1:0] count_pin_i,
  tick_if.source    ticks
);
  logic [DIV_BITS-1:0]    div;
  logic [FS_DIV_BITS-1:0] fs_div;
  logic [1:0]             fs_sync;
  logic                   fs_last;
  logic [1:0]             pin_meta;
  logic [1:0]             pin_sync;
  logic [1:0]             pin_last;
  logic                   fs_tick;
  logic                   fs8_tick;

  // Free-running divider of the high-frequency clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div <= '0;
    end else begin
      div <= div + DIV_BITS'(1);
    end
  end

  // Pins are foreign to clk_i, so two flops before any edge logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fs_sync  <= 2'h0;
      fs_last  <= 1'b0;
      pin_meta <= 2'h3;
      pin_sync <= 2'h3;
      pin_last <= 2'h3;
    end else begin
      fs_sync  <= {fs_sync[0], low_freq_clock_i};
      fs_last  <= fs_sync[1];
      pin_meta <= count_pin_i;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // Divide the low-frequency ticks by eight
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fs_div <= '0;
    end else if (fs_tick) begin
      fs_div <= fs_div + FS_DIV_BITS'(1);
    end
  end

  // Strobes last one clk_i cycle each
  assign fs_tick  = fs_sync[1] & ~fs_last;
  assign fs8_tick = fs_tick & (&fs_div);
  assign ticks.tick[CK_TAP11] = tap_select_i ? fs8_tick : (&div[TAP_SLOW-1:0]);
  assign ticks.tick[CK_TAP7]  = &div[TAP_MID1-1:0];
  assign ticks.tick[CK_TAP5]  = &div[TAP_MID2-1:0];
  assign ticks.tick[CK_TAP3]  = &div[TAP_FAST-1:0];
  assign ticks.tick[CK_FS]    = fs_tick;
  assign ticks.tick[CK_FC2]   = div[0];
  assign ticks.tick[CK_FC]    = 1'b1;
  // Event counters advance on the falling pin edge
  assign ticks.pin_fall       = pin_last & ~pin_sync;
endmodule

// ===== core/count_unit.sv
// One up-counter with compare, overflow and output flip-flop
module count_unit
  import timer_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             run_i,
  input  wire logic             tick_i,
  input  wire kind_e            kind_i,
  input  wire logic [WIDTH-1:0] period_i,
  input  wire logic [WIDTH-1:0] width_i,
  input  wire logic             preset_i,
  output logic      [WIDTH-1:0] count_o,
  output logic                  match_o,
  output logic                  ff_o
);
  logic [WIDTH-1:0] next_count;
  logic             hit_period;
  logic             hit_width;
  logic             at_top;

  // Below two bits there is no room for both a width and a period
  if (WIDTH < 2) begin : g_width_check
    $error("count_unit needs WIDTH of at least 2");
  end

  // Compare against live registers; no shadow copy of the period
  assign next_count = count_o + WIDTH'(1);
  assign hit_period = next_count == period_i;
  assign hit_width  = next_count == width_i;
  assign at_top     = &count_o;

  // Counting sequence per kind
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= '0;
      match_o <= 1'b0;
      ff_o    <= 1'b0;
    end else if (!run_i) begin
      count_o <= '0;
      match_o <= 1'b0;
      ff_o    <= preset_i; // Output level follows preset while stopped
    end else begin
      match_o <= 1'b0;
      if (tick_i) begin
        unique case (kind_i)
          kind_timer, kind_div: begin
            if (hit_period) begin
              count_o <= '0;
              match_o <= 1'b1;
              ff_o    <= (kind_i == kind_div) ? ~ff_o : ff_o;
            end else begin
              count_o <= next_count;
            end
          end
          kind_pwm: begin
            if (at_top) begin
              count_o <= '0;
              match_o <= 1'b1;
              ff_o    <= ~ff_o;
            end else begin
              count_o <= next_count;
              ff_o    <= hit_width ? ~ff_o : ff_o;
            end
          end
          kind_ppg: begin
            if (hit_period) begin
              count_o <= '0;
              match_o <= 1'b1;
              ff_o    <= ~ff_o;
            end else begin
              count_o <= next_count;
              ff_o    <= hit_width ? ~ff_o : ff_o;
            end
          end
        endcase
      end
    end
  end
endmodule

// ===== core/dual_timer_top.sv
// Dual cascadable timer core with Wishbone registers and interrupt
//
// The Wishbone slave port and the address map were left to the implementer.
module dual_timer_top
  import timer_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        low_freq_clock_i,
  input  wire logic [1:0]  count_pin_i,
  output logic      [1:0]  unit_pin_o,
  output logic             irq_o
);
  // Register storage
  logic [7:0]  ctrl [2];
  logic [7:0]  period [2];
  logic [7:0]  width_buf [2];
  logic [7:0]  width_act [2];
  logic [1:0]  status;
  logic [1:0]  mask;
  logic [1:0]  config_bits;

  // Decoded control fields
  logic [2:0]  mode [2];
  logic [2:0]  clk_sel [2];
  logic [1:0]  run_bit;
  logic [1:0]  preset;
  logic        cascade;
  logic        low_speed;

  // Counter side signals
  logic [1:0]  tick8;
  logic [1:0]  run8;
  kind_e       kind8 [2];
  logic [7:0]  count8 [2];
  logic [1:0]  match8;
  logic [1:0]  ff8;
  logic        tick16;
  logic        run16;
  kind_e       kind16;
  logic [15:0] count16;
  logic        match16;
  logic        ff16;

  // Bus side signals
  logic        bus_req;
  logic        bus_wr;
  logic [7:0]  wdata;
  logic [31:0] next_rdata;
  logic [1:0]  irq_set;
  logic [1:0]  irq_clr;
  logic [1:0]  width_load;

  tick_if ticks ();

  clock_source_gen u_src (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .tap_select_i     (config_bits[CFG_TAP_BIT]),
    .low_freq_clock_i (low_freq_clock_i),
    .count_pin_i      (count_pin_i),
    .ticks            (ticks.source)
  );

  // Source clock legality per mode and power state
  function automatic logic clock_allowed(input logic [2:0] m, input logic [2:0] s,
                                         input logic slow);
    logic ok;
    ok = 1'b0;
    if (!slow) begin
      unique case (m)
        MODE_TIMER8, MODE_TIMER16, MODE_PPG16: ok = (s <= CK_TAP3) || (s == CK_PIN);
        MODE_DIV8:   ok = s <= CK_TAP3;
        MODE_PWM8:   ok = s != CK_PIN;
        MODE_WARMUP: ok = s == CK_FS;
        MODE_PWM16:  ok = 1'b1;
        MODE_RSVD:   ok = 1'b0;
      endcase
    end else begin
      unique case (m)
        MODE_TIMER8, MODE_TIMER16, MODE_PPG16: ok = (s == CK_TAP11) || (s == CK_PIN);
        MODE_DIV8:   ok = s == CK_TAP11;
        MODE_PWM8:   ok = (s == CK_TAP11) || (s == CK_FS);
        MODE_WARMUP: ok = s == CK_FC;
        MODE_PWM16:  ok = (s == CK_TAP11) || (s == CK_FS) || (s == CK_PIN);
        MODE_RSVD:   ok = 1'b0;
      endcase
    end
    return ok;
  endfunction

  // Mode code to counting kind
  function automatic kind_e kind_of(input logic [2:0] m);
    kind_e k;
    k = kind_timer;
    unique case (m)
      MODE_TIMER8, MODE_TIMER16, MODE_WARMUP, MODE_RSVD: k = kind_timer;
      MODE_DIV8:                                         k = kind_div;
      MODE_PWM8, MODE_PWM16:                             k = kind_pwm;
      MODE_PPG16:                                        k = kind_ppg;
    endcase
    return k;
  endfunction

  // Field decode of the configuration register and the upper control register
  assign low_speed = config_bits[CFG_LOWSPD_BIT];
  assign cascade   = mode[1][2];
  assign wdata     = wb_dat_i[7:0];

  // Per-unit 8-bit counters, idle while cascaded
  for (genvar j = 0; j < 2; j++) begin : g_unit
    assign mode[j]    = ctrl[j][CTRL_MODE_LSB +: 3];
    assign clk_sel[j] = ctrl[j][CTRL_CLK_LSB +: 3];
    assign run_bit[j] = ctrl[j][CTRL_RUN_BIT];
    assign preset[j]  = ctrl[j][CTRL_PRESET_BIT];
    assign kind8[j]   = kind_of(mode[j]);
    // Own pin for event counting, else the chosen internal tap
    assign tick8[j]   = clock_allowed(mode[j], clk_sel[j], low_speed) &
                        ((clk_sel[j] == CK_PIN) ? ticks.pin_fall[j]
                                                : ticks.tick[clk_sel[j]]);
    assign run8[j]    = run_bit[j] & ~cascade & ~mode[j][2] & (mode[j] != MODE_RSVD);
    assign width_load[j] = cascade ? (~run16 | match16) : (~run8[j] | match8[j]);

    count_unit #(
      .WIDTH (8)
    ) u_unit (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .run_i    (run8[j]),
      .tick_i   (tick8[j]),
      .kind_i   (kind8[j]),
      .period_i (period[j]),
      .width_i  (width_act[j]),
      .preset_i (preset[j]),
      .count_o  (count8[j]),
      .match_o  (match8[j]),
      .ff_o     (ff8[j])
    );
  end

  // Cascaded counter: upper mode and run, lower clock select
  assign kind16 = kind_of(mode[1]);
  assign run16  = cascade & run_bit[1];
  assign tick16 = clock_allowed(mode[1], clk_sel[0], low_speed) &
                  ((clk_sel[0] == CK_PIN) ? ticks.pin_fall[0]
                                          : ticks.tick[clk_sel[0]]);

  count_unit #(
    .WIDTH (16)
  ) u_cascade (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .run_i    (run16),
    .tick_i   (tick16),
    .kind_i   (kind16),
    .period_i ({period[1], period[0]}),
    .width_i  ({width_act[1], width_act[0]}),
    .preset_i (preset[1]),
    .count_o  (count16),
    .match_o  (match16),
    .ff_o     (ff16)
  );

  // Pins drive the inverse of the flip-flop
  assign unit_pin_o[0] = ~ff8[0];
  assign unit_pin_o[1] = cascade ? ~ff16 : ~ff8[1];

  // Bus decode; one wait state, ack drops after one cycle
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
  assign irq_set = {match8[1] | match16, match8[0]};
  assign irq_clr = (bus_wr && wb_adr_i == OFS_STATUS) ? wdata[1:0] : 2'h0;

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      OFS_CTRL0:   next_rdata[7:0] = ctrl[0];
      OFS_CTRL1:   next_rdata[7:0] = ctrl[1];
      OFS_PERIOD0: next_rdata[7:0] = period[0];
      OFS_PERIOD1: next_rdata[7:0] = period[1];
      OFS_WIDTH0:  next_rdata[7:0] = width_act[0];
      OFS_WIDTH1:  next_rdata[7:0] = width_act[1];
      OFS_COUNT0:  next_rdata[7:0] = cascade ? count16[7:0] : count8[0];
      OFS_COUNT1:  next_rdata[7:0] = cascade ? count16[15:8] : count8[1];
      OFS_STATUS:  next_rdata[1:0] = status;
      OFS_MASK:    next_rdata[1:0] = mask;
      OFS_CONFIG:  next_rdata[1:0] = config_bits;
      default:     next_rdata      = 32'h0000_0000;
    endcase
  end

  // Bus handshake and read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? next_rdata : wb_dat_o;
    end
  end

  // Writable registers; software keeps fields steady while running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl        <= '{CTRL_RESET, CTRL_RESET};
      period      <= '{PERIOD_RESET, PERIOD_RESET};
      width_buf   <= '{WIDTH_RESET, WIDTH_RESET};
      mask        <= IRQ_RESET;
      config_bits <= CFG_RESET;
    end else if (bus_wr) begin
      unique case (wb_adr_i)
        OFS_CTRL0:   ctrl[0]      <= wdata;
        OFS_CTRL1:   ctrl[1]      <= wdata;
        OFS_PERIOD0: period[0]    <= wdata;
        OFS_PERIOD1: period[1]    <= wdata;
        OFS_WIDTH0:  width_buf[0] <= wdata;
        OFS_WIDTH1:  width_buf[1] <= wdata;
        OFS_MASK:    mask         <= wdata[1:0];
        OFS_CONFIG:  config_bits  <= wdata[1:0];
        default:     mask         <= mask;
      endcase
    end
  end

  // Pulse width shadow: reloads at period end, or at once if stopped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      width_act <= '{WIDTH_RESET, WIDTH_RESET};
    end else begin
      for (int j = 0; j < 2; j++) begin
        if (width_load[j]) begin
          width_act[j] <= width_buf[j];
        end
      end
    end
  end

  // Sticky match flags; a new match beats a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= IRQ_RESET;
    end else begin
      status <= (status & ~irq_clr) | irq_set;
    end
  end

  assign irq_o = |(status & mask);
endmodule

// ===== tb/pin_partner.sv
// Model of the far-side pins: low-frequency oscillator and event inputs
module pin_partner #(
  parameter int LF_HALF = 5
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] pulse_i,
  output logic            busy_o,
  output logic            low_freq_clock_o,
  output logic      [1:0] count_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] lf_cnt;
  logic [3:0] ph;
  logic [1:0] sel;
  // Oscillator and pulse phase; the oscillator runs free like a crystal
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lf_cnt <= 4'h0;
      ph     <= 4'h0;
      sel    <= 2'h0;
    end else begin
      lf_cnt <= (lf_cnt == 4'(2 * LF_HALF - 1)) ? 4'h0 : lf_cnt + 4'h1;
      if (ph != 4'h0) begin
        ph <= ph + 4'h1;
      end else if (pulse_i != 2'h0) begin
        ph  <= 4'h1;
        sel <= pulse_i;
      end
    end
  end
  // Pins idle high; each level lasts several cycles, well past the synchroniser
  assign low_freq_clock_o = lf_cnt >= 4'(LF_HALF);
  assign count_pin_o      = (ph != 4'h0 && !ph[3]) ? ~sel : 2'h3;
  assign busy_o           = ph != 4'h0;
endmodule

// ===== tb/dual_timer_monitor.sv
// Port-level assertions of the dual timer core
module dual_timer_monitor
  import timer_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  input  wire logic        low_freq_clock_i,
  input  wire logic [1:0]  count_pin_i,
  input  wire logic [1:0]  unit_pin_o,
  input  wire logic        irq_o
);
  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  logic [7:0] period0;
  logic [1:0] mask;
  wire        taken = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr    = taken & wb_we_i & wb_sel_i[0];
  wire        rd    = taken & ~wb_we_i;
  // Shadow of software settings, rebuilt from the bus writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl0   <= 8'h00;
      ctrl1   <= 8'h00;
      period0 <= 8'h00;
      mask    <= 2'h0;
    end else if (wr) begin
      if (wb_adr_i == OFS_CTRL0) ctrl0 <= wb_dat_i[7:0];
      if (wb_adr_i == OFS_CTRL1) ctrl1 <= wb_dat_i[7:0];
      if (wb_adr_i == OFS_PERIOD0) period0 <= wb_dat_i[7:0];
      if (wb_adr_i == OFS_MASK) mask <= wb_dat_i[1:0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_read(a);
    rd && wb_adr_i == a;
  endsequence
  // Lower unit stopped, not cascaded, settings untouched
  sequence s_idle;
    !ctrl0[CTRL_RUN_BIT] && !ctrl1[2] && $stable(ctrl0);
  endsequence
  chk_ack_answer: assert property (taken |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_no_stray: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  chk_unmapped_zero: assert property (rd && wb_adr_i > OFS_CONFIG |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_ctrl_readback: assert property (
    s_read(OFS_CTRL0) |=> wb_dat_o == {24'h0, ctrl0})
    else $error("control readback wrong");
  chk_count_bound: assert property (
    s_read(OFS_COUNT0) ##0 (ctrl0[CTRL_RUN_BIT] && ctrl0[2:0] == MODE_TIMER8 && !ctrl1[2]
      && period0 != 8'h00) |=> wb_dat_o[7:0] < period0)
    else $error("count reached period");
  chk_stop_zero: assert property (
    s_read(OFS_COUNT0) ##0 (!ctrl0[CTRL_RUN_BIT] && !ctrl1[2]) |=> wb_dat_o == 32'h0)
    else $error("stopped count not zero");
  chk_irq_masked: assert property (irq_o |-> mask != 2'h0)
    else $error("irq with all masked");
  chk_pin_preset: assert property (
    s_idle ##1 s_idle |-> unit_pin_o[0] == !ctrl0[CTRL_PRESET_BIT])
    else $error("stopped pin not preset");
endmodule
bind dual_timer_top dual_timer_monitor i_dual_timer_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .low_freq_clock_i(low_freq_clock_i),
  .count_pin_i(count_pin_i), .unit_pin_o(unit_pin_o), .irq_o(irq_o));

// ===== tb/dual_cascadable_timer_core_tb.sv
// Self-checking bench of the dual timer core
module dual_cascadable_timer_core_tb
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [1:0]  pulse    = 2'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        irq_o;
  logic        busy;
  logic        lf_clk;
  logic [1:0]  unit_pin_o;
  logic [1:0]  count_pin;
  logic [31:0] rd;
  int          n_errors   = 0;
  int          num_checks = 0;
  int          cycles     = 0;
  int          t0;

  dual_timer_top i_dual_timer_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .low_freq_clock_i(lf_clk), .count_pin_i(count_pin), .unit_pin_o(unit_pin_o),
    .irq_o(irq_o));
  pin_partner i_pin_partner (.clk_i(clk_i), .rst_i(rst_i), .pulse_i(pulse), .busy_o(busy),
    .low_freq_clock_o(lf_clk), .count_pin_o(count_pin));

  always #20 clk_i = ~clk_i;
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_errors++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // One classic Wishbone cycle; waits for ack however long it takes
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb_xfer(1'b1, a, {24'h0, d});
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    wb_xfer(1'b0, a, 32'h0);
    check(rd, exp, what);
  endtask
  task automatic pin_pulse(input logic [1:0] p);
    @(posedge clk_i);
    pulse <= p;
    @(posedge clk_i);
    pulse <= 2'h0;
    do @(posedge clk_i); while (busy === 1'b1);
  endtask
  // Start the lower unit, let it run, see whether it moved at all
  task automatic src_check(input logic [7:0] cfg, input logic [7:0] ctrl, input logic moves);
    wr(OFS_CONFIG, cfg);
    wr(OFS_CTRL0, ctrl);
    repeat (200) @(posedge clk_i);
    wb_xfer(1'b0, OFS_COUNT0, 32'h0);
    check({31'h0, rd[7:0] != 8'h00}, {31'h0, moves}, "source legality");
    wr(OFS_CTRL0, ctrl & 8'hF7);
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset state, unmapped and read-only places
    rd_chk(OFS_CTRL0, 32'h0, "ctrl0 reset");
    rd_chk(OFS_PERIOD1, 32'h0, "period1 reset");
    rd_chk(OFS_STATUS, 32'h0, "status reset");
    rd_chk(8'h30, 32'h0, "unmapped read");
    wr(OFS_COUNT0, 8'hFF);
    rd_chk(OFS_COUNT0, 32'h0, "count write ignored");
    check({30'h0, unit_pin_o}, 32'h3, "idle pins");
    check({31'h0, irq_o}, 32'h0, "idle irq");
    for (int m = 0; m < 8; m++) begin
      wr(OFS_CTRL1, 8'(m));
      rd_chk(OFS_CTRL1, 32'(m), "mode code");
    end
    wr(OFS_CTRL1, 8'h00);
    // Preset drives the stopped divider pin, inverted
    wr(OFS_CTRL0, 8'h81);
    repeat (2) @(posedge clk_i);
    check({30'h0, unit_pin_o}, 32'h2, "preset pin");
    wr(OFS_CTRL0, 8'h00);
    // Timer on the fc/8 tap with period 5: one match per 40 clocks
    wr(OFS_PERIOD0, 8'h05);
    wr(OFS_MASK, 8'h01);
    wr(OFS_CTRL0, 8'h38);
    while (irq_o !== 1'b1) @(posedge clk_i);
    t0 = cycles;
    wr(OFS_STATUS, 8'h01);
    while (irq_o !== 1'b1) @(posedge clk_i);
    check(32'(cycles - t0), 32'(5 * 8), "match interval");
    rd_chk(OFS_STATUS, 32'h1, "status set");
    wr(OFS_MASK, 8'h00);
    check({31'h0, irq_o}, 32'h0, "masked irq");
    for (int i = 0; i < 4; i++) begin
      rd_chk(OFS_STATUS, 32'h1, "status sticky");
    end
    wr(OFS_CTRL0, 8'h30);
    rd_chk(OFS_COUNT0, 32'h0, "stop clears");
    wr(OFS_STATUS, 8'h01);
    rd_chk(OFS_STATUS, 32'h0, "status cleared");
    // Source clocks allowed per mode and state
    wr(OFS_PERIOD0, 8'hFF);
    wr(OFS_WIDTH0, 8'h80);
    src_check(8'h00, 8'h38, 1'b1);
    src_check(8'h00, 8'h68, 1'b0);
    src_check(8'h00, 8'h6A, 1'b1);
    src_check(8'h00, 8'h5A, 1'b1);
    src_check(8'h00, 8'h49, 1'b0);
    src_check(8'h00, 8'h39, 1'b1);
    src_check(8'h02, 8'h38, 1'b0);
    src_check(8'h02, 8'h4A, 1'b1);
    // Slowest tap switched to the low-frequency clock over eight
    src_check(8'h03, 8'h08, 1'b1);
    wr(OFS_CONFIG, 8'h00);
    // Cascaded event count, clocked from the lower pin only
    wr(OFS_PERIOD0, 8'h03);
    wr(OFS_PERIOD1, 8'h00);
    wr(OFS_MASK, 8'h02);
    wr(OFS_CTRL0, 8'h73);
    wr(OFS_CTRL1, 8'h0C);
    pin_pulse(2'h2);
    rd_chk(OFS_COUNT0, 32'h0, "upper pin ignored");
    pin_pulse(2'h1);
    pin_pulse(2'h1);
    rd_chk(OFS_COUNT0, 32'h2, "lower pin edges");
    pin_pulse(2'h1);
    rd_chk(OFS_STATUS, 32'h2, "cascaded match");
    check({31'h0, irq_o}, 32'h1, "cascaded irq");
    wr(OFS_CTRL1, 8'h04);
    rd_chk(OFS_COUNT0, 32'h0, "cascade stop");
    wr(OFS_STATUS, 8'h02);
    check({31'h0, irq_o}, 32'h0, "irq cleared");
    // Cascaded pulse generator, width 2 of period 6 on the lower fc/8 tap
    wr(OFS_PERIOD0, 8'h06);
    wr(OFS_WIDTH0, 8'h02);
    wr(OFS_CTRL0, 8'h33);
    wr(OFS_CTRL1, 8'h0F);
    while (irq_o !== 1'b1) @(posedge clk_i);
    check({30'h0, unit_pin_o}, 32'h3, "pulse end level");
    wr(OFS_STATUS, 8'h02);
    // Past the width toggle, well before the period toggle
    repeat (20) @(posedge clk_i);
    check({30'h0, unit_pin_o}, 32'h1, "pulse active level");
    results();
  end
endmodule
